// ===== testbench.sv
// self-checking testbench of the watchdog timer block
`timescale 1ns/100ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hready, stop_mode, idle_mode;
   logic hreadyout, hresp, wdt_reset_req, watchdog_interrupt;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int errors, check_count, irq_n, n;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   wdt_top #(.DET_LOG2(8)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .stop_mode(stop_mode),
      .idle_mode(idle_mode), .wdt_reset_req(wdt_reset_req),
      .watchdog_interrupt(watchdog_interrupt));
   // 20 mhz clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // pulse tally, read as differences across a window
   always @(posedge hclk) begin
      if (watchdog_interrupt === 1'b1) irq_n++;
   end
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
         errors++;
      end
   endtask
   task give_verdict;
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one single word transfer; waits on ready, no fixed latency assumed
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // cycles between two consecutive interrupt pulses
   task gap(output int m);
      m = 0;
      @(posedge hclk iff watchdog_interrupt === 1'b1);
      do begin
         @(posedge hclk);
         m++;
      end while (watchdog_interrupt !== 1'b1);
   endtask
   task t_regs;
      bus(1'b0, 8'h3C, 32'h0);
      chk("aux", 32'h106, q & 32'h3C7);
      bus(1'b0, 8'h34, 32'h0);
      chk("ctrl", 32'h0, q);
      bus(1'b0, 8'h38, 32'h0);
      chk("code", 32'h0, q);
   endtask
   task t_wdrst;
      n = 0;
      bus(1'b1, 8'h34, 32'hF);
      for (int i = 0; i < 60 && wdt_reset_req !== 1'b1; i++) @(posedge hclk);
      while (wdt_reset_req === 1'b1) begin
         n++;
         @(posedge hclk);
      end
      chk("rst_len", 32'd24, n);
      bus(1'b0, 8'h3C, 32'h0);
      chk("aux_rst", 32'h104, q & 32'h1C4);
   endtask
   task t_period;
      for (int t = 0; t < 4; t++) begin
         bus(1'b1, 8'h34, 32'h8 | (t << 1));
         gap(n);
         gap(n);
         chk("period", 256 >> (2 * t), n);
      end
      bus(1'b1, 8'h3C, 32'h1);
      gap(n);
      gap(n);
      chk("period_dv", 32'd8, n);
      bus(1'b1, 8'h3C, 32'h0);
      bus(1'b1, 8'h34, 32'hF);
      bus(1'b0, 8'h3C, 32'h0);
      chk("act_once", 32'h0, q & 32'h4);
   endtask
   // code writes at well under three quarters of a 16 cycle period
   task clr(input logic [7:0] c, input logic e);
      int k;
      bus(1'b1, 8'h34, 32'hC);
      @(posedge hclk iff watchdog_interrupt === 1'b1);
      // one edge on, so the tally of that pulse has surely settled
      @(posedge hclk);
      k = irq_n;
      repeat (12) begin
         bus(1'b1, 8'h38, {24'h0, c});
         repeat (3) @(posedge hclk);
      end
      chk("clr_irq", e, (irq_n - k) != 0);
   endtask
   task t_off;
      int k;
      bus(1'b1, 8'h38, 32'h4E);
      bus(1'b1, 8'h34, 32'h4);
      bus(1'b1, 8'h38, 32'hB1);
      k = irq_n;
      repeat (100) @(posedge hclk);
      bus(1'b0, 8'h3C, 32'h0);
      chk("off_aux", 32'h0, q & 32'h132);
      chk("off_irq", 32'h0, irq_n - k);
      bus(1'b1, 8'h34, 32'hC);
   endtask
   // freeze mid-period so a restart from zero would be seen as late
   task t_frz(input logic s);
      int k;
      @(posedge hclk iff watchdog_interrupt === 1'b1);
      repeat (8) @(posedge hclk);
      stop_mode <= s;
      idle_mode <= !s;
      k = irq_n;
      repeat (100) @(posedge hclk);
      chk("frozen", 32'h0, irq_n - k);
      stop_mode <= 1'b0;
      idle_mode <= 1'b0;
      k = irq_n;
      repeat (12) @(posedge hclk);
      chk("resume", 32'h1, irq_n - k);
      bus(1'b1, 8'h38, 32'h4E);
   endtask
   // hang guard, well above the few thousand cycles the run needs
   initial begin
      repeat (30000) @(posedge hclk);
      errors++;
      give_verdict;
   end
   initial begin
      {hresetn, hsel, hwrite, stop_mode, idle_mode} = 5'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_wdrst;
      t_period;
      clr(8'h4E, 1'b0);
      clr(8'h55, 1'b1);
      clr(8'hB1, 1'b1);
      t_off;
      t_frz(1'b1);
      t_frz(1'b0);
      give_verdict;
   end
endmodule
bind wdt_top wdt_checker #(.DET_LOG2(DET_LOG2)) u_chk (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .stop_mode(stop_mode), .idle_mode(idle_mode),
   .wdt_reset_req(wdt_reset_req), .watchdog_interrupt(watchdog_interrupt));

// ===== wdt_binctr.sv
// free-running divider feeding the two-stage binary counter
`timescale 1ns/100ps
module wdt_binctr #(
   parameter int DIV_W = wdt_pkg::DET_LOG2_MAX + 1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control side
   wdt_cnt_if.cnt c
);
   logic [DIV_W-1:0] div_reg, div_next;
   logic [1:0] bc_reg, bc_next;
   logic ovf_reg, ovf_next;
   logic [DIV_W-1:0] mask;
   logic tick;
   int k;

   // refused at elaboration: too few divider bits for four ticks
   if (DIV_W < 8) begin : g_bad_width
      $error("wdt_binctr: DIV_W too small");
   end

   // tick every quarter detection time; 4 ticks overflow
   always_comb begin
      k = DIV_W - 4 - 2 * int'(c.time_sel) + int'(c.dv_sel);
      for (int i = 0; i < DIV_W; i++) begin
         mask[i] = (i <= k);
      end
      tick = &(div_reg | ~mask);
   end

   // divider never cleared by the clear code, only frozen
   always_comb begin
      div_next = c.pause ? div_reg : div_reg + DIV_W'(1);
      bc_next = bc_reg;
      ovf_next = 1'b0;
      if (c.clear || !c.run) begin
         bc_next = 2'h0;
      end else if (!c.pause && tick) begin
         bc_next = bc_reg + 2'h1; // wraps, so repeats periodically
         ovf_next = (bc_reg == 2'h3);
      end
   end

   // register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= '0;
         bc_reg <= 2'h0;
         ovf_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         bc_reg <= bc_next;
         ovf_reg <= ovf_next;
      end
   end

   assign c.ovf = ovf_reg;
   assign c.count = bc_reg;
endmodule

// ===== wdt_checker.sv
// port-level assertions for the watchdog timer block
`timescale 1ns/100ps
module wdt_checker #(
   parameter int DET_LOG2 = 25
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // power modes
   input wire logic stop_mode,
   input wire logic idle_mode,
   // watchdog outputs
   input wire logic wdt_reset_req,
   input wire logic watchdog_interrupt
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [4:0] hi_reg;
   logic [4:0] hi_next;
   logic rd_a;
   // read address phase seen by the slave
   assign rd_a = hsel && hready && htrans == 2'h2 && !hwrite;
   // length of the current reset request, zero while low
   always_comb begin
      hi_next = wdt_reset_req ? hi_reg + 5'h01 : 5'h00;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_reg <= 5'h00;
      end else begin
         hi_reg <= hi_next;
      end
   end
   a_rst_len_max: assert property (hi_reg <= 5'h18)
      else $error("reset request too long");
   a_rst_len_full: assert property ($fell(wdt_reset_req) |-> hi_reg == 5'h18)
      else $error("reset request wrong length");
   a_irq_min_gap: assert property (watchdog_interrupt |=> !watchdog_interrupt[*3])
      else $error("interrupt pulses too close");
   a_irq_not_rst: assert property (watchdog_interrupt |-> !$rose(wdt_reset_req))
      else $error("interrupt and reset together");
   a_stop_freeze: assert property (stop_mode[*3] |-> !watchdog_interrupt && !$rose(wdt_reset_req))
      else $error("overflow during stop");
   a_idle_freeze: assert property (idle_mode[*3] |-> !watchdog_interrupt && !$rose(wdt_reset_req))
      else $error("overflow during idle");
   a_ctrl_no_read: assert property (rd_a && haddr[7:0] == 8'h34 |=> hrdata == 32'h0)
      else $error("control one returned data");
   a_code_no_read: assert property (rd_a && haddr[7:0] == 8'h38 |=> hrdata == 32'h0)
      else $error("code register returned data");
endmodule

// ===== wdt_cnt_if.sv
// carrier between watchdog control and its divider/counter
`timescale 1ns/100ps
interface wdt_cnt_if;
   logic clear;
   logic run;
   logic pause;
   logic [1:0] time_sel;
   logic dv_sel;
   logic ovf;
   logic [1:0] count;
   modport ctl (output clear, output run, output pause, output time_sel,
      output dv_sel, input ovf, input count);
   modport cnt (input clear, input run, input pause, input time_sel,
      input dv_sel, output ovf, output count);
endinterface

// ===== wdt_pkg.sv
// constants shared by the watchdog timer block
package wdt_pkg;
   // register byte addresses, compared on the low address bits
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL1 = 8'h34;
   localparam logic [7:0] ADDR_CODE = 8'h38;
   localparam logic [7:0] ADDR_AUX = 8'h3C;
   // code register values
   localparam logic [7:0] CODE_CLEAR = 8'h4E;
   localparam logic [7:0] CODE_DISABLE = 8'hB1;
   // control one fields
   localparam int EN_BIT = 3;
   localparam int TIME_LSB = 1;
   localparam int OUT_BIT = 0;
   localparam logic EN_RST = 1'h1;
   localparam logic [1:0] TIME_RST = 2'h0;
   localparam logic OUT_RST = 1'h1;
   // aux register: stage select in, status out
   localparam int DV_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_ACT_BIT = 2;
   localparam int ST_CNT_LSB = 4;
   localparam int ST_TIME_LSB = 6;
   localparam int ST_EN_BIT = 8;
   localparam int ST_RST_BIT = 9;
   // ahb encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // timing
   localparam int CLK_NS = 50;
   localparam int RESET_NS = 1200;
   localparam int RESET_CYC = (RESET_NS / CLK_NS < 1) ? 1 :
      RESET_NS / CLK_NS;
   localparam int DET_LOG2_MAX = 25;
endpackage

// ===== wdt_top.sv
// watchdog timer with its ahb-lite register slave
`timescale 1ns/100ps
module wdt_top #(
   parameter int DET_LOG2 = wdt_pkg::DET_LOG2_MAX
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // power modes
   input wire logic stop_mode,
   input wire logic idle_mode,
   // watchdog outputs
   output logic wdt_reset_req,
   output logic watchdog_interrupt
);
   localparam int RC_W = $clog2(wdt_pkg::RESET_CYC + 1);

   // refused at elaboration: shorter times leave no quarter tick
   if (DET_LOG2 < 7) begin : g_bad_time
      $error("wdt_top: DET_LOG2 too small");
   end

   wdt_cnt_if cif ();

   // address-phase capture for the following data phase
   logic wr_pend_reg, wr_pend_next;
   logic [wdt_pkg::ADDR_W-1:0] wr_addr_reg, wr_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic hreadyout_reg;
   logic hresp_reg;

   // control one and aux state
   logic en_reg, en_next;
   logic [1:0] time_reg, time_next;
   logic act_reg, act_next;
   logic dv_reg, dv_next;
   logic run_reg, run_next;
   logic clr_reg, clr_next;

   // request outputs
   logic [RC_W-1:0] rst_cnt_reg, rst_cnt_next;
   logic rst_out_reg, rst_out_next;
   logic irq_reg, irq_next;

   // decoded bus events
   logic addr_ok;
   logic rd_take;
   logic wr_ctrl1;
   logic wr_code;
   logic wr_aux;
   logic [7:0] wbyte;
   logic wdt_fire;

   // a transfer is taken when selected, nonseq and bus ready
   always_comb begin
      addr_ok = hsel && hready && (htrans == wdt_pkg::HTRANS_NONSEQ);
      rd_take = addr_ok && !hwrite;
      wbyte = hwdata[7:0];
      wr_ctrl1 = wr_pend_reg && (wr_addr_reg == wdt_pkg::ADDR_CTRL1);
      wr_code = wr_pend_reg && (wr_addr_reg == wdt_pkg::ADDR_CODE);
      wr_aux = wr_pend_reg && (wr_addr_reg == wdt_pkg::ADDR_AUX);
   end

   // write is only acted on for whole-word transfers
   always_comb begin
      wr_pend_next = addr_ok && hwrite && (hsize == wdt_pkg::HSIZE_WORD);
      wr_addr_next = haddr[wdt_pkg::ADDR_W-1:0];
   end

   // read data prepared at address phase so it leaves a flop
   always_comb begin
      hrdata_next = 32'h0000_0000;
      if (rd_take && haddr[wdt_pkg::ADDR_W-1:0] == wdt_pkg::ADDR_AUX) begin
         hrdata_next[wdt_pkg::DV_BIT] = dv_reg;
         hrdata_next[wdt_pkg::ST_RUN_BIT] = run_reg;
         hrdata_next[wdt_pkg::ST_ACT_BIT] = act_reg;
         hrdata_next[wdt_pkg::ST_CNT_LSB +: 2] = cif.count;
         hrdata_next[wdt_pkg::ST_TIME_LSB +: 2] = time_reg;
         hrdata_next[wdt_pkg::ST_EN_BIT] = en_reg;
         hrdata_next[wdt_pkg::ST_RST_BIT] = rst_out_reg;
      end
      // control one and code register read as zero
   end

   // bus registers; zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b0;
         hresp_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   // an overflow with reset action fires the internal reset
   assign wdt_fire = cif.ovf && act_reg;

   // control state; a watchdog reset beats any write in the same cycle
   always_comb begin
      en_next = en_reg;
      time_next = time_reg;
      act_next = act_reg;
      dv_next = dv_reg;
      run_next = run_reg;
      clr_next = 1'b0;
      if (wdt_fire) begin
         // enable, time, action and run back to reset values; aux stage select dv_reg keeps its value
         en_next = wdt_pkg::EN_RST;
         time_next = wdt_pkg::TIME_RST;
         act_next = wdt_pkg::OUT_RST;
         run_next = 1'b1;
         clr_next = 1'b1;
      end else begin
         if (wr_ctrl1) begin
            en_next = wbyte[wdt_pkg::EN_BIT];
            time_next = wbyte[wdt_pkg::TIME_LSB +: 2];
            // once cleared, the action bit only stays clear
            act_next = act_reg && wbyte[wdt_pkg::OUT_BIT];
            if (wbyte[wdt_pkg::EN_BIT]) begin
               run_next = 1'b1;
            end
         end
         if (wr_code) begin
            if (wbyte == wdt_pkg::CODE_CLEAR) begin
               clr_next = 1'b1;
            end else if (wbyte == wdt_pkg::CODE_DISABLE && !en_reg) begin
               run_next = 1'b0;
            end
            // any other code is ignored
         end
         if (wr_aux) begin
            dv_next = wbyte[wdt_pkg::DV_BIT];
         end
      end
   end

   // control registers; enabled and reset action out of reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_reg <= wdt_pkg::EN_RST;
         time_reg <= wdt_pkg::TIME_RST;
         act_reg <= wdt_pkg::OUT_RST;
         dv_reg <= 1'b0;
         run_reg <= 1'b1;
         clr_reg <= 1'b0;
      end else begin
         en_reg <= en_next;
         time_reg <= time_next;
         act_reg <= act_next;
         dv_reg <= dv_next;
         run_reg <= run_next;
         clr_reg <= clr_next;
      end
   end

   // reset request held a fixed, bounded number of cycles
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      if (wdt_fire) begin
         rst_cnt_next = RC_W'(wdt_pkg::RESET_CYC);
      end else if (rst_cnt_reg != '0) begin
         rst_cnt_next = rst_cnt_reg - RC_W'(1);
      end
      rst_out_next = (rst_cnt_next != '0);
      // interrupt is not gated by any master flag
      irq_next = cif.ovf && !act_reg;
   end

   // request output registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_cnt_reg <= '0;
         rst_out_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         rst_cnt_reg <= rst_cnt_next;
         rst_out_reg <= rst_out_next;
         irq_reg <= irq_next;
      end
   end

   // drive the counter through the carrier
   assign cif.clear = clr_reg;
   assign cif.run = run_reg;
   assign cif.pause = stop_mode || idle_mode;
   assign cif.time_sel = time_reg;
   assign cif.dv_sel = dv_reg;

   // divider width one above DET_LOG2, equal to the longest detection exponent with dv set
   wdt_binctr #(
      .DIV_W(DET_LOG2 + 1)
   ) u_ctr (
      .hclk(hclk),
      .hresetn(hresetn),
      .c(cif.cnt)
   );

   // outputs straight from flops
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign wdt_reset_req = rst_out_reg;
   assign watchdog_interrupt = irq_reg;
endmodule
